// >>> rtl/flash_host_regs.svh
// Timing counts and pin field positions for the parallel flash host.
// Assumes a 200 MHz clock; every count is derived from a time in ns.
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define CLK_PERIOD_NS 5
`define T_SETUP_NS 10
`define T_SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_PULSE_NS 35
`define T_PULSE_CYC ((`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_ACCESS_NS 70
`define T_ACCESS_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RESET_NS 500
`define T_RESET_CYC ((`T_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W 21
`define DATA_W 16
`define PROT_A6 6
`define PROT_A1 1
`define PROT_A0 0
`define TOP_DATA_BIT 15
`endif

// >>> rtl/flash_host_pkg.sv
// Types shared by the parallel flash host: operation code, request and pin groups.
// Assumes the timing header is compiled alongside.
package flash_host_pkg;
   typedef enum logic [2:0] {
      op_read = 3'h0,
      op_write = 3'h1,
      op_reset = 3'h2,
      op_protect = 3'h3,
      op_unprotect = 3'h4
   } op_t;
   typedef struct packed {
      op_t op;
      logic [20:0] addr;
      logic [15:0] data;
      logic byte_mode;
      logic low_byte_addr;
      logic accel;
   } req_t;
   typedef struct packed {
      logic chip_sel_n;
      logic out_en_n;
      logic wr_en_n;
      logic reset_n;
      logic id_voltage;
      logic protect_accel_pin;
      logic accel_high_voltage;
      logic width_select_n;
      logic [20:0] addr;
   } pins_t;
endpackage

// >>> rtl/flash_host.sv
// Host controller that drives an asynchronous parallel NOR flash by pins.
// Assumes pin inputs are synchronous to clock; the board resolves the bus.
// Notes on behaviour
// RL1 - Read: select and output enable low, write enable high, valid address.
// RL2 - Command write: write enable and chip select low, output enable high.
// RL3 - Device latches each write's address and data as a command.
// RL4 - Width select high gives sixteen active data lines.
// RL5 - Width select low: low eight active, top line carries low byte address.
// RL6 - Address bits 20..0 in word mode, 20..low byte address in byte mode.
// RL7 - After reset the device reads array without any command.
// RL8 - Banks stay in array read until a command changes them.
// RL9 - Program data is byte or word by the width select level.
// RL10 - Fast program mode programs with two write cycles, not four.
// RL11 - Erase works on one, several or all sectors by sector bits.
// RL12 - Four banks chosen uniquely by bank address bits.
// RL13 - Accelerate voltage enters fast program mode and unprotects sectors.
// RL14 - Host applies accelerate voltage only for two-cycle programming; code raises it for every write with accel set.
// RL15 - Protect pin low keeps the two outer boot sectors protected.
// RL16 - Autoselect codes come from a separate register, normal read timing.
// RL17 - Reads in one bank run while another bank programs or erases.
// RL18 - Suspended erase allows other locations, never the erased sector.
// RL19 - Protect write with identification voltage, A6 low, A1 high, A0 low.
// RL20 - Reset pin low aborts, tri-states and returns to array read.
// RL21 - Output enable high puts device outputs in high impedance.
// RL22 - High voltage qualifiers are separate from plain logic levels.
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_host #(
   parameter int unsigned SETUP_CYC = `T_SETUP_CYC,
   parameter int unsigned PULSE_CYC = `T_PULSE_CYC,
   parameter int unsigned ACCESS_CYC = `T_ACCESS_CYC,
   parameter int unsigned RESET_CYC = `T_RESET_CYC
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic req_valid,
   output logic req_ready,
   input wire flash_host_pkg::req_t req,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output flash_host_pkg::pins_t pins,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe_n,
   input wire logic [15:0] dq_in
);
   typedef enum logic [4:0] {
      st_idle = 5'h01,
      st_setup = 5'h02,
      st_pulse = 5'h04,
      st_hold = 5'h08,
      st_reset = 5'h10
   } state_t;

   state_t state_reg, state_next;
   logic [9:0] count_reg;
   flash_host_pkg::req_t cur_reg;
   flash_host_pkg::pins_t pins_next;
   logic [15:0] rsp_data_reg;
   logic rsp_valid_reg;
   logic wr_drive_reg;

   wire is_read = cur_reg.op == flash_host_pkg::op_read;
   wire is_reset = cur_reg.op == flash_host_pkg::op_reset;
   wire is_prot = cur_reg.op == flash_host_pkg::op_protect ||
                  cur_reg.op == flash_host_pkg::op_unprotect;
   wire count_done = count_reg == 10'h000;
   wire take = req_valid && req_ready;

   function automatic logic [9:0] load(input int unsigned cyc);
      load = 10'((cyc > 0) ? cyc - 1 : 0);
   endfunction

   assign req_ready = state_reg == st_idle;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data = rsp_data_reg;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         st_idle: begin
            if (req_valid)
               state_next = (req.op == flash_host_pkg::op_reset) ?
                            st_reset : st_setup;
         end
         st_setup: if (count_done) state_next = st_pulse;
         st_pulse: if (count_done) state_next = st_hold;
         st_hold: if (count_done) state_next = st_idle;
         st_reset: if (count_done) state_next = st_hold;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_reg <= st_idle;
         count_reg <= 10'h000;
         cur_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (take) begin
            cur_reg <= req;
            count_reg <= (req.op == flash_host_pkg::op_reset) ?
                         load(RESET_CYC) : load(SETUP_CYC);
         end else if (state_reg != state_next) begin
            unique case (state_next)
               st_pulse: count_reg <= is_read ? load(ACCESS_CYC) :
                                      load(PULSE_CYC);
               default: count_reg <= load(SETUP_CYC);
            endcase
         end else if (!count_done) begin
            count_reg <= count_reg - 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin levels
   always_comb begin
      pins_next.chip_sel_n = 1'b1;
      pins_next.out_en_n = 1'b1;
      pins_next.wr_en_n = 1'b1;
      // RL20 reset pulse
      pins_next.reset_n = !(state_reg == st_reset);
      // RL19 protect voltage
      pins_next.id_voltage = is_prot && state_reg != st_idle &&
                             state_reg != st_reset;
      // RL10 RL14 accel write voltage
      pins_next.accel_high_voltage = cur_reg.accel &&
                                     cur_reg.op == flash_host_pkg::op_write;
      // RL13 accel pin high
      pins_next.protect_accel_pin = 1'b1;
      // RL5 width select
      pins_next.width_select_n = !cur_reg.byte_mode;
      pins_next.addr = cur_reg.addr;
      if (is_prot) begin
         // RL19 protect address pattern
         pins_next.addr[`PROT_A6] = cur_reg.op ==
                                    flash_host_pkg::op_unprotect;
         pins_next.addr[`PROT_A1] = 1'b1;
         pins_next.addr[`PROT_A0] = 1'b0;
      end
      if (state_reg == st_pulse) begin
         pins_next.chip_sel_n = 1'b0;
         // RL1 read strobes
         pins_next.out_en_n = !is_read;
         // RL2 write strobes
         pins_next.wr_en_n = is_read;
      end else if (state_reg == st_setup || state_reg == st_hold) begin
         pins_next.chip_sel_n = is_reset;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         pins <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
                   reset_n: 1'b0, default: '0};
         wr_drive_reg <= 1'b0;
         dq_out <= 16'h0000;
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 16'h0000;
      end else begin
         pins <= pins_next;
         wr_drive_reg <= !is_read && !is_reset &&
                         (state_next == st_pulse || state_reg == st_pulse);
         dq_out <= cur_reg.data;
         // RL5 low byte address on top line
         if (cur_reg.byte_mode)
            dq_out[`TOP_DATA_BIT] <= cur_reg.low_byte_addr;
         rsp_valid_reg <= state_reg == st_pulse && is_read && count_done;
         if (state_reg == st_pulse && is_read && count_done)
            // RL9 byte or word data
            rsp_data_reg <= cur_reg.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data pin enables: low means driven
   wire drive_top = wr_drive_reg ||
                    (cur_reg.byte_mode && state_reg != st_idle && !is_reset);
   // RL4 word lanes
   assign dq_oe_n[7:0] = {8{!wr_drive_reg}};
   assign dq_oe_n[14:8] = {7{!(wr_drive_reg && !cur_reg.byte_mode)}};
   assign dq_oe_n[15] = !drive_top;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Strobe, lane, protect address, reset, accelerate voltage and read answer checks
   read_strobe_a: assert property ( // RL1
      @(posedge clock) disable iff (!rstn)
      !pins.out_en_n |-> pins.wr_en_n && !pins.chip_sel_n)
      else $error("output enable low with write enable low");
   write_strobe_a: assert property ( // RL2
      @(posedge clock) disable iff (!rstn)
      !pins.wr_en_n |-> pins.out_en_n && !pins.chip_sel_n)
      else $error("write enable without chip select");
   no_contention_a: assert property ( // RL21
      @(posedge clock) disable iff (!rstn)
      !pins.out_en_n |-> dq_oe_n[7:0] == 8'hff)
      else $error("host drives data while device outputs");
   byte_lanes_a: assert property ( // RL5
      @(posedge clock) disable iff (!rstn)
      !pins.width_select_n |-> dq_oe_n[14:8] == 7'h7f)
      else $error("upper lanes driven in byte mode");
   prot_pattern_a: assert property ( // RL19
      @(posedge clock) disable iff (!rstn)
      pins.id_voltage && !pins.wr_en_n |->
      pins.addr[1] && !pins.addr[0])
      else $error("protect write with wrong address pattern");
   reset_quiet_a: assert property ( // RL20
      @(posedge clock) disable iff (!rstn)
      !pins.reset_n |-> pins.chip_sel_n && pins.wr_en_n)
      else $error("bus cycle during reset pulse");
   accel_write_a: assert property ( // RL14
      @(posedge clock) disable iff (!rstn)
      pins.accel_high_voltage |-> pins.out_en_n)
      else $error("accelerate voltage during read");
   read_answer_a: assert property ( // RL1
      @(posedge clock) disable iff (!rstn)
      $fell(pins.out_en_n) |-> ##[1:40] rsp_valid)
      else $error("read answer missing");
   cov_read_c: cover property (@(posedge clock) rsp_valid);
   cov_write_c: cover property (@(posedge clock) $fell(pins.wr_en_n));
   cov_reset_c: cover property (@(posedge clock) $fell(pins.reset_n));
   cov_prot_c: cover property (@(posedge clock)
      pins.id_voltage && !pins.wr_en_n);
endmodule

// >>> testbench/flash_dev_model.sv
// Behavioural model of the parallel NOR flash beside the host controller.
// Assumes the bench resolves the data bus and feeds it back on dq.
`timescale 1ns/1ps
module flash_dev_model #(
   // Command codes and identity word of the model; values are arbitrary
   parameter logic [15:0] ARM_CMD = 16'h00a0,
   parameter logic [15:0] ERASE_CMD = 16'h0030,
   parameter logic [15:0] AUTOSEL_CMD = 16'h0090,
   parameter logic [15:0] EXIT_CMD = 16'h00f0,
   parameter logic [15:0] ID_WORD = 16'h5ac3
) (
   input wire flash_host_pkg::pins_t pins,
   input wire logic [15:0] dq,
   output logic [15:0] dev_dq,
   output logic [15:0] dev_oe
);
   logic [15:0] mem [256];
   logic [20:0] cmd_addr_reg;
   logic [15:0] cmd_data_reg;
   logic armed_reg = 1'b0;
   logic protect_reg = 1'b0;
   logic autosel_reg = 1'b0;
   wire live = pins.reset_n && !pins.chip_sel_n;
   wire rd_sel = live && !pins.out_en_n && pins.wr_en_n;
   wire [3:0] sector_select_bits = pins.addr[7:4];
   // outer boot sectors locked while the pin is low
   wire boot_locked = !pins.protect_accel_pin &&
      (sector_select_bits == 4'h0 || sector_select_bits == 4'hf);
   // identity word from its own register
   wire [15:0] word = autosel_reg ? ID_WORD : mem[pins.addr[7:0]];
   ////////////////////////////////////////////////////////////////////////
   // array after power-up
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = {i[7:0], ~i[7:0]};
      end
   end
   // read gating
   // Byte lane chosen by dq15, driven by the host as the low byte address
   assign dev_dq = pins.width_select_n ? word :
      {8'h00, dq[15] ? word[15:8] : word[7:0]};
   assign dev_oe = !rd_sel ? 16'h0000 :
      pins.width_select_n ? 16'hffff : 16'h00ff;
   // command latch
   // Sampled 1 ns after write enable falls; the host's data lanes were driven a cycle earlier
   always @(negedge pins.wr_en_n or negedge pins.reset_n) begin
      if (pins.reset_n !== 1'b1) begin
         armed_reg = 1'b0;
         autosel_reg = 1'b0;
      end else begin
         #1;
         if (live) begin
            cmd_addr_reg = pins.addr;
            cmd_data_reg = pins.width_select_n ? dq : {8'h00, dq[7:0]};
            // identification voltage is its own qualifier
            if (pins.id_voltage && pins.addr[1] && !pins.addr[0]) begin
               protect_reg = !pins.addr[6];
            end else if (armed_reg) begin
               if (!boot_locked)
                  mem[pins.addr[7:0]] = cmd_data_reg;
               armed_reg = 1'b0;
            end else if (cmd_data_reg == ERASE_CMD) begin
               // erase clears only its own sector
               for (int i = 0; i < 256; i++) begin
                  if (i[7:4] == sector_select_bits && !boot_locked)
                     mem[i] = 16'hffff;
               end
            end else begin
               autosel_reg = cmd_data_reg == AUTOSEL_CMD ||
                  (autosel_reg && cmd_data_reg != EXIT_CMD);
               armed_reg = pins.accel_high_voltage &&
                  cmd_data_reg == ARM_CMD;
            end
         end
      end
   end
endmodule

// >>> testbench/flash_host_tb_top.sv
// Self-checking bench for the flash host controller and a device model.
// Assumes the model answers reads combinationally from its pins.
`timescale 1ns/1ps
module flash_host_tb_top;
   localparam int RST_CYC = 4;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   logic rsp_valid;
   flash_host_pkg::req_t req = '0;
   logic [15:0] rsp_data, dq_out, dq_oe_n, dq_in, dev_dq, dev_oe, got;
   logic [15:0] last_dq = 16'h0000;
   flash_host_pkg::pins_t pins, wr_seen, rd_seen;
   int n_mismatch = 0;
   int num_checks = 0;
   int rst_len = 0;
   int low_run = 0;
   flash_host #(.RESET_CYC(RST_CYC)) u_flash_host (.clock(clock),
      .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
   flash_dev_model u_flash_dev_model (.pins(pins), .dq(dq_in),
      .dev_dq(dev_dq), .dev_oe(dev_oe));
   // Undriven lanes show the inverse of their last level
   assign dq_in = (~dq_oe_n & dq_out) | (dq_oe_n & dev_oe & dev_dq) |
      (dq_oe_n & ~dev_oe & ~last_dq);
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      last_dq <= dq_in;
      if (!pins.chip_sel_n && !pins.wr_en_n) wr_seen <= pins;
      if (!pins.chip_sel_n && !pins.out_en_n) rd_seen <= pins;
      if (!pins.reset_n) begin
         low_run <= low_run + 1;
      end else if (low_run != 0) begin
         rst_len <= low_run;
         low_run <= 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [20:0] seen,
      input logic [20:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_req(input flash_host_pkg::op_t op, input logic [20:0] a,
      input logic [15:0] d, input logic bm, input logic lba, input logic acc);
      int n;
      got = 16'hxxxx;
      @(posedge clock);
      req <= '{op, a, d, bm, lba, acc};
      req_valid <= 1'b1;
      n = 0;
      do @(posedge clock); while (req_ready !== 1'b1 && ++n < 300);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         if (rsp_valid === 1'b1) got = rsp_data;
      end while (req_ready !== 1'b1 && ++n < 300);
      check("ready", req_ready, 1'b1);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reads;
      do_req(flash_host_pkg::op_read, 21'h1c0012, 0, 0, 0, 0);
      check("word", got, 16'h12ed);
      check("rd we", rd_seen.wr_en_n, 1'b1);
      check("rd width", rd_seen.width_select_n, 1'b1);
      check("rd addr", rd_seen.addr, 21'h1c0012);
      for (int k = 0; k < 2; k++) begin
         do_req(flash_host_pkg::op_read, 21'h34, 0, 1, k[0], 0);
         check("byte", got, k ? 16'h0034 : 16'h00cb);
         check("rd width", rd_seen.width_select_n, 1'b0);
      end
   endtask
   task automatic t_writes;
      do_req(flash_host_pkg::op_write, 21'h1abc5, 16'h5a3c, 0, 0, 0);
      check("wr oe", wr_seen.out_en_n, 1'b1);
      check("wr addr", wr_seen.addr, 21'h1abc5);
      check("wr id", wr_seen.id_voltage, 1'b0);
      check("wr acc", wr_seen.accel_high_voltage, 1'b0);
      check("wp pin", wr_seen.protect_accel_pin, 1'b1);
      check("cmd", u_flash_dev_model.cmd_data_reg, 16'h5a3c);
      do_req(flash_host_pkg::op_write, 21'h1abc5, 16'hbeef, 1, 0, 0);
      check("cmd byte", u_flash_dev_model.cmd_data_reg, 16'h00ef);
      do_req(flash_host_pkg::op_write, 21'h40, 16'h00a0, 0, 0, 1);
      check("accel", wr_seen.accel_high_voltage, 1'b1);
      do_req(flash_host_pkg::op_write, 21'h40, 16'hc0de, 0, 0, 1);
      do_req(flash_host_pkg::op_read, 21'h40, 0, 0, 0, 0);
      check("fast prog", got, 16'hc0de);
   endtask
   task automatic t_protect;
      for (int k = 0; k < 2; k++) begin
         do_req(k ? flash_host_pkg::op_unprotect : flash_host_pkg::op_protect,
            21'h0310c5, 0, 0, 0, 0);
         check("prot addr", wr_seen.addr, k ? 21'h0310c6 : 21'h031086);
         check("prot id", wr_seen.id_voltage, 1'b1);
         check("prot state", u_flash_dev_model.protect_reg, !k);
      end
   endtask
   task automatic t_reset_op;
      do_req(flash_host_pkg::op_write, 21'h50, 16'h00a0, 0, 0, 1);
      do_req(flash_host_pkg::op_reset, 21'h0, 0, 0, 0, 0);
      check("reset len", rst_len, RST_CYC);
      do_req(flash_host_pkg::op_write, 21'h50, 16'h1234, 0, 0, 1);
      do_req(flash_host_pkg::op_read, 21'h50, 0, 0, 0, 0);
      check("aborted", got, 16'h50af);
   endtask
   task automatic t_modes;
      do_req(flash_host_pkg::op_write, 21'h60, 16'h0030, 0, 0, 0);
      do_req(flash_host_pkg::op_read, 21'h65, 0, 0, 0, 0);
      check("erased", got, 16'hffff);
      do_req(flash_host_pkg::op_read, 21'h75, 0, 0, 0, 0);
      check("other sector", got, 16'h758a);
      do_req(flash_host_pkg::op_write, 21'h0, 16'h0090, 0, 0, 0);
      do_req(flash_host_pkg::op_read, 21'h12, 0, 0, 0, 0);
      check("autoselect", got, 16'h5ac3);
      do_req(flash_host_pkg::op_write, 21'h0, 16'h00f0, 0, 0, 0);
      do_req(flash_host_pkg::op_read, 21'h12, 0, 0, 0, 0);
      check("array again", got, 16'h12ed);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clock);
      check("rst cs", pins.chip_sel_n, 1'b1);
      check("rst pin", pins.reset_n, 1'b0);
      rstn <= 1'b1;
      t_reads;
      t_writes;
      t_protect;
      t_reset_op;
      t_modes;
      end_of_test;
   end
   // Whole run needs a few hundred cycles; this leaves wide margin
   initial begin
      #20000;
      n_mismatch++;
      end_of_test;
   end
endmodule
